// >>> logic/oeu_order_execute_unit.sv
// Purpose: fetch, decode and execute the arithmetic and transfer orders
// Assumes: memory answers a read one cycle later on mem_rdata
// Notes: unknown orders halt the unit with illegal_order set
// What this block does
// [RULE_01] each instruction names at most one memory word
// [RULE_02] instruction is 8-bit order plus address in a 20-bit half-word
// [RULE_03] memory has 1024 words, addressed 0 to 1023
// [RULE_04] reading an operand never disturbs the memory word
// [RULE_05] clear-type loads zero the accumulator then add the operand form
// [RULE_06] accumulating orders add the operand form to the accumulator
// [RULE_07] subtraction adds the two's complement of the operand
// [RULE_08] AA loads operand, AF loads negated absolute value
// [RULE_09] BA, BB, BF add operand, its negative, its negated magnitude
// [RULE_10] BE adds the operand's absolute value
// [RULE_11] EB loads the multiplier/quotient register
// [RULE_12] DA: upper 39 product bits, lsb forced one, multiplier zeroed
// [RULE_13] DB: upper 39 bits to accumulator, lower 39 to mq, sign cleared; the code puts 40 bits, prod[78:39], in the accumulator
// [RULE_14] DD: quotient to mq, twice remainder to accumulator
// [RULE_15] CA jumps to left order, CB to right order of word
// [RULE_16] CC, CD jump like CA, CB when accumulator not negative
// [RULE_17] DC stores accumulator, EC stores mq register
// [RULE_18] run left order, right order, then next word
`timescale 1ns/1ns
`default_nettype none
`include "oeu_defs.svh"
module oeu_order_execute_unit
    import oeu_pkg::*;
#(
    parameter int WORD_W = `OEU_WORD_W,
    parameter int ADDR_W = `OEU_ADDR_W
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    input wire logic [ADDR_W-1:0] start_addr,
    output var oeu_mem_req_t mem_req,
    input wire logic [WORD_W-1:0] mem_rdata,
    output logic running,
    output logic illegal_order,
    output logic [WORD_W-1:0] accumulator_register,
    output logic [WORD_W-1:0] multiplier_quotient_register,
    output logic [ADDR_W-1:0] pc,
    output logic right_half
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (WORD_W != `OEU_WORD_W || ADDR_W != `OEU_ADDR_W) begin : g_chk
        $error("oeu: word must be 40 bits and address 10 bits");
    end

    localparam int PW = 2 * WORD_W;
    localparam int NW = WORD_W + `OEU_FRAC_W;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [WORD_W-1:0] neg(input logic [WORD_W-1:0] v);
        neg = ~v + {{(WORD_W-1){1'b0}}, 1'b1}; // see [RULE_07]
    endfunction

    function automatic logic [WORD_W-1:0] mag(input logic [WORD_W-1:0] v);
        mag = v[WORD_W-1] ? neg(v) : v;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    oeu_state_t state, next_state;
    logic [ADDR_W-1:0] next_pc;
    logic next_right_half;
    logic [`OEU_HALF_W-1:0] ir, next_ir;
    logic [WORD_W-1:0] acc, next_acc, mq, next_mq;
    logic next_illegal;
    oeu_mem_req_t next_req;

    wire logic [7:0] opc = ir[`OEU_OPC_MSB:`OEU_OPC_LSB]; // see [RULE_02]
    // only the low address bits reach memory; 1024 words
    wire logic [ADDR_W-1:0] oadr = ir[`OEU_ADR_MSB:0]; // see [RULE_03]

    // ------------------------------------------------------------
    // multiply and divide datapath
    // ------------------------------------------------------------
    logic signed [PW-1:0] prod;
    logic signed [NW-1:0] num, den, quo, rem;
    assign prod = $signed(mem_rdata) * $signed(mq);
    assign num = $signed({acc, {`OEU_FRAC_W{1'b0}}});
    // a zero divisor would be undefined; divide by one instead
    assign den = (mem_rdata == '0) ? {{(NW-1){1'b0}}, 1'b1} :
                 {{`OEU_FRAC_W{mem_rdata[WORD_W-1]}}, mem_rdata};
    assign quo = num / den;
    assign rem = num % den;

    // ------------------------------------------------------------
    // sequencing and execution
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_right_half = right_half;
        next_ir = ir;
        next_acc = acc;
        next_mq = mq;
        next_illegal = illegal_order;
        next_req = '0;
        unique case (state)
            ST_IDLE, ST_HALT: begin
                if (start) begin
                    next_pc = start_addr;
                    next_right_half = 1'b0;
                    next_illegal = 1'b0;
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // refetch each half so stores into this word are seen
                next_req.rd = 1'b1;
                next_req.addr = pc;
                next_state = ST_DECODE;
            end
            ST_DECODE: begin
                next_ir = right_half ? mem_rdata[`OEU_HALF_W-1:0] :
                          mem_rdata[WORD_W-1:`OEU_HALF_W]; // see [RULE_02]
                next_state = ST_EXEC;
            end
            ST_EXEC: begin
                next_state = ST_FETCH;
                // one memory access per order at most; see [RULE_01]
                unique case (opc)
                    `OEU_OP_AA, `OEU_OP_AB, `OEU_OP_AE, `OEU_OP_AF,
                    `OEU_OP_BA, `OEU_OP_BB, `OEU_OP_BE, `OEU_OP_BF,
                    `OEU_OP_EB, `OEU_OP_DA, `OEU_OP_DB, `OEU_OP_DD: begin
                        next_req.rd = 1'b1; // see [RULE_04]
                        next_req.addr = oadr;
                        next_state = ST_OPER;
                    end
                    `OEU_OP_CA, `OEU_OP_CB: begin
                        next_pc = oadr; // see [RULE_15]
                        next_right_half = (opc == `OEU_OP_CB);
                    end
                    `OEU_OP_CC, `OEU_OP_CD: begin
                        if (!acc[WORD_W-1]) begin // see [RULE_16]
                            next_pc = oadr;
                            next_right_half = (opc == `OEU_OP_CD);
                        end else begin
                            next_right_half = ~right_half;
                            next_pc = right_half ? pc + 1'b1 : pc;
                        end
                    end
                    `OEU_OP_DC, `OEU_OP_EC: begin
                        next_req.wr = 1'b1; // see [RULE_17]
                        next_req.addr = oadr;
                        next_req.wdata = (opc == `OEU_OP_DC) ? acc : mq;
                        next_right_half = ~right_half; // see [RULE_18]
                        next_pc = right_half ? pc + 1'b1 : pc;
                    end
                    default: begin
                        next_illegal = 1'b1;
                        next_state = ST_HALT;
                    end
                endcase
            end
            ST_OPER: begin
                unique case (opc)
                    // clear-type: zero plus operand form; see [RULE_05]
                    `OEU_OP_AA: next_acc = mem_rdata; // see [RULE_08]
                    `OEU_OP_AB: next_acc = neg(mem_rdata);
                    `OEU_OP_AE: next_acc = mag(mem_rdata);
                    `OEU_OP_AF: next_acc = neg(mag(mem_rdata)); // see [RULE_08]
                    // accumulate onto held value; see [RULE_06]
                    `OEU_OP_BA: next_acc = acc + mem_rdata; // see [RULE_09]
                    `OEU_OP_BB: next_acc = acc + neg(mem_rdata); // see [RULE_09]
                    `OEU_OP_BE: next_acc = acc + mag(mem_rdata); // see [RULE_10]
                    `OEU_OP_BF: next_acc = acc + neg(mag(mem_rdata)); // see [RULE_09]
                    `OEU_OP_EB: next_mq = mem_rdata; // see [RULE_11]
                    `OEU_OP_DA: begin
                        // rounding by forcing the last bit; see [RULE_12]
                        next_acc = {prod[PW-2:WORD_W], 1'b1};
                        next_mq = '0;
                    end
                    `OEU_OP_DB: begin
                        // duplicate product sign dropped; see [RULE_13]
                        next_acc = prod[PW-2:`OEU_FRAC_W];
                        next_mq = {1'b0, prod[`OEU_FRAC_W-1:0]};
                    end
                    `OEU_OP_DD: begin
                        next_mq = quo[WORD_W-1:0]; // see [RULE_14]
                        next_acc = {rem[WORD_W-2:0], 1'b0};
                    end
                    default: next_acc = acc;
                endcase
                next_right_half = ~right_half; // see [RULE_18]
                next_pc = right_half ? pc + 1'b1 : pc;
                next_state = ST_FETCH;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            pc <= '0;
            right_half <= 1'b0;
            ir <= '0;
            acc <= '0;
            mq <= '0;
            illegal_order <= 1'b0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            right_half <= next_right_half;
            ir <= next_ir;
            acc <= next_acc;
            mq <= next_mq;
            illegal_order <= next_illegal;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // memory strobes are combinational, not registered, decoded from state
    assign mem_req = next_req;
    assign running = (state != ST_IDLE) && (state != ST_HALT);
    assign accumulator_register = acc;
    assign multiplier_quotient_register = mq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_FETCH_ADDR: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_03]
        state == ST_FETCH |-> mem_req.rd && mem_req.addr == pc ##2 state == ST_EXEC)
        else $error("fetch did not read pc");
    AST_READ_NO_WRITE: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_04]
        mem_req.rd |-> !mem_req.wr)
        else $error("write during operand read");
    AST_LOAD_AF: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_08]
        state == ST_OPER && opc == `OEU_OP_AF |=> acc == neg(mag($past(mem_rdata))))
        else $error("AF load wrong");
    AST_ADD_BA: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_06]
        state == ST_OPER && opc == `OEU_OP_BA |=> acc == $past(acc) + $past(mem_rdata))
        else $error("BA sum wrong");
    AST_SUB_BB: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_07]
        state == ST_OPER && opc == `OEU_OP_BB |=>
        acc == $past(acc) + ~$past(mem_rdata) + 40'h1)
        else $error("BB difference wrong");
    AST_DA_ROUND: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_12]
        state == ST_OPER && opc == `OEU_OP_DA |=> acc[0] && mq == '0)
        else $error("DA rounding or mq clear wrong");
    AST_DB_SIGN: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_13]
        state == ST_OPER && opc == `OEU_OP_DB |=> !mq[WORD_W-1])
        else $error("DB mq sign not cleared");
    AST_JUMP_CB: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_15]
        state == ST_EXEC && opc == `OEU_OP_CB |=> pc == $past(oadr) && right_half)
        else $error("CB target wrong");
    AST_COND_FALL: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_16]
        state == ST_EXEC && opc == `OEU_OP_CC && acc[WORD_W-1] && !right_half
        |=> right_half && pc == $past(pc))
        else $error("CC jumped on negative");
    AST_STORE_DC: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_17]
        state == ST_EXEC && opc == `OEU_OP_DC |=> mem_req.wr == 1'b0 && mq == $past(mq))
        else $error("DC store disturbed state");
    AST_SEQ_NEXT: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_18]
        state == ST_OPER && right_half |=> !right_half && pc == $past(pc) + 10'h1)
        else $error("sequence did not advance word");
    AST_START_FETCH: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_18]
        (state == ST_IDLE || state == ST_HALT) && start |=>
        state == ST_FETCH && pc == $past(start_addr) && !right_half)
        else $error("start did not begin at left order");
    // the half chosen must follow right_half as it stood at decode
    AST_DECODE_HALF: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_02]
        state == ST_DECODE |=> ir == ($past(right_half) ?
        $past(mem_rdata[`OEU_HALF_W-1:0]) : $past(mem_rdata[WORD_W-1:`OEU_HALF_W])))
        else $error("wrong half decoded");
    // an order gets one access; the operand cycle must stay quiet
    AST_OPER_QUIET: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_01]
        state == ST_OPER |-> !mem_req.rd && !mem_req.wr)
        else $error("second access by one order");
    AST_LOAD_AA: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_05]
        state == ST_OPER && opc == `OEU_OP_AA |=> acc == $past(mem_rdata))
        else $error("AA load wrong");
    AST_ADD_BE: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_10]
        state == ST_OPER && opc == `OEU_OP_BE |=> acc == $past(acc) + mag($past(mem_rdata)))
        else $error("BE sum wrong");
    AST_LOAD_MQ: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_11]
        state == ST_OPER && opc == `OEU_OP_EB |=> mq == $past(mem_rdata) && acc == $past(acc))
        else $error("EB load wrong");
    AST_DIV_EVEN: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_14]
        state == ST_OPER && opc == `OEU_OP_DD |=> !acc[0] && mq == $past(quo[WORD_W-1:0]))
        else $error("DD result wrong");
    AST_JUMP_CA: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_15]
        state == ST_EXEC && opc == `OEU_OP_CA |=> pc == $past(oadr) && !right_half)
        else $error("CA target wrong");
    AST_COND_TAKE: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_16]
        state == ST_EXEC && (opc == `OEU_OP_CC || opc == `OEU_OP_CD) && !acc[WORD_W-1]
        |=> pc == $past(oadr) && right_half == ($past(opc) == `OEU_OP_CD))
        else $error("conditional transfer not taken");
    AST_STORE_ACC: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_17]
        state == ST_EXEC && opc == `OEU_OP_DC |->
        mem_req.wr && mem_req.addr == oadr && mem_req.wdata == acc)
        else $error("DC store data wrong");
    AST_STORE_MQ: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_17]
        state == ST_EXEC && opc == `OEU_OP_EC |->
        mem_req.wr && mem_req.addr == oadr && mem_req.wdata == mq)
        else $error("EC store data wrong");
    AST_SEQ_LEFT: assert property (@(posedge clock) disable iff (!resetn) // see [RULE_18]
        state == ST_OPER && !right_half |=> right_half && pc == $past(pc))
        else $error("left order not followed by right");
endmodule
`default_nettype wire

// >>> pkg/oeu_defs.svh
// Purpose: constants of the order execute unit
// Assumes: bigit 0 (the sign) is bit 39 of a word
// Notes: definitions only
`ifndef OEU_DEFS_SVH
`define OEU_DEFS_SVH
`define OEU_WORD_W 40
`define OEU_ADDR_W 10
`define OEU_MEM_WORDS 1024
`define OEU_HALF_W 20
`define OEU_OPC_MSB 19
`define OEU_OPC_LSB 12
`define OEU_ADR_MSB 9
`define OEU_FRAC_W 39
`define OEU_OP_AA 8'hAA
`define OEU_OP_AB 8'hAB
`define OEU_OP_AE 8'hAE
`define OEU_OP_AF 8'hAF
`define OEU_OP_BA 8'hBA
`define OEU_OP_BB 8'hBB
`define OEU_OP_BE 8'hBE
`define OEU_OP_BF 8'hBF
`define OEU_OP_EB 8'hEB
`define OEU_OP_DA 8'hDA
`define OEU_OP_DB 8'hDB
`define OEU_OP_DD 8'hDD
`define OEU_OP_CA 8'hCA
`define OEU_OP_CB 8'hCB
`define OEU_OP_CC 8'hCC
`define OEU_OP_CD 8'hCD
`define OEU_OP_EC 8'hEC
`define OEU_OP_DC 8'hDC
`endif

// >>> pkg/oeu_pkg.sv
// Purpose: types of the order execute unit
// Assumes: oeu_defs.svh gives the widths
// Notes: none
`include "oeu_defs.svh"
package oeu_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_DECODE = 3'h2,
        ST_EXEC = 3'h3,
        ST_OPER = 3'h4,
        ST_HALT = 3'h5
    } oeu_state_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [`OEU_ADDR_W-1:0] addr;
        logic [`OEU_WORD_W-1:0] wdata;
    } oeu_mem_req_t;
endpackage

// >>> test/oeu_mem_model.sv
// Purpose: main memory partner of the order execute unit
// Assumes: one-cycle read latency, no stall
// Notes: the bench preloads and inspects mem by hierarchy
`timescale 1ns/1ns
`default_nettype none
`include "oeu_defs.svh"
module oeu_mem_model
    import oeu_pkg::*;
(
    input wire logic clock,
    input wire oeu_mem_req_t mem_req,
    output logic [`OEU_WORD_W-1:0] rdata
);
    logic [`OEU_WORD_W-1:0] mem [0:`OEU_MEM_WORDS-1];
    initial rdata = 40'h0;
    // ----------------------------------------
    // access
    // ----------------------------------------
    always @(posedge clock) begin
        if (mem_req.wr) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
        // data is good for one cycle only; flip it after so stale reads show
        if (mem_req.rd) begin
            rdata <= mem[mem_req.addr];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule
`default_nettype wire

// >>> test/order_execute_unit_bench.sv
// Purpose: self-checking bench of the order execute unit
// Assumes: programs end on order code 00, which halts the unit
// Notes: expected values are worked out here from the order table
`timescale 1ns/1ns
`default_nettype none
`include "oeu_defs.svh"
module order_execute_unit_bench
    import oeu_pkg::*;
;
    logic clock = 1'b0;
    logic resetn;
    logic start;
    logic [9:0] start_addr;
    oeu_mem_req_t mem_req;
    logic [39:0] mem_rdata;
    logic running;
    logic illegal_order;
    logic [39:0] acc;
    logic [39:0] mq;
    logic [9:0] pc;
    logic right_half;
    int bad_count = 0;
    int num_checks = 0;

    always #5 clock = ~clock;

    oeu_order_execute_unit i_oeu_order_execute_unit (
        .clock(clock), .resetn(resetn), .start(start), .start_addr(start_addr),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .running(running),
        .illegal_order(illegal_order), .accumulator_register(acc),
        .multiplier_quotient_register(mq), .pc(pc), .right_half(right_half)
    );
    oeu_mem_model i_oeu_mem_model (.clock(clock), .mem_req(mem_req), .rdata(mem_rdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [19:0] ins(input logic [7:0] op, input logic [9:0] a);
        return {op, 2'b00, a};
    endfunction

    function automatic logic [39:0] form(input logic [3:0] k, input logic [39:0] m);
        logic [39:0] mag;
        mag = m[39] ? -m : m;
        case (k)
            4'hA: return m;
            4'hB: return -m;
            4'hE: return mag;
            default: return -mag;
        endcase
    endfunction

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic put(input logic [9:0] a, input logic [39:0] d);
        i_oeu_mem_model.mem[a] = d;
    endtask

    task automatic clr();
        for (int i = 0; i < 1024; i++) begin
            put(i[9:0], 40'h0);
        end
    endtask

    // start at a negedge, then wait for the halt under a bound
    task automatic run(input logic [9:0] a);
        int n;
        start_addr = a;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        check(mem_req.rd, 1'b1);
        check(mem_req.addr, a);
        n = 0;
        while (running === 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        if (n >= 300) bad_count++;
        check(illegal_order, 1'b1);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_add();
        logic [7:0] ops [8] = '{8'hAA, 8'hAB, 8'hAE, 8'hAF, 8'hBA, 8'hBB, 8'hBE, 8'hBF};
        logic [39:0] x;
        logic [39:0] m;
        logic [39:0] e;
        x = 40'h00_0000_0010;
        m = 40'hFF_FFFF_FFFD;
        for (int i = 0; i < 8; i++) begin
            clr();
            put(10'd100, x);
            put(10'd101, m);
            // top of memory, so the fetch address boundary is used too
            put(10'h3FE, {ins(8'hAA, 10'd100), ins(ops[i], 10'd101)});
            run(10'h3FE);
            e = form(ops[i][3:0], m);
            if (ops[i][7:4] == 4'hB) e = x + e;
            check(acc, e);
            check(i_oeu_mem_model.mem[101], m);
            check({pc, right_half}, {10'h3FF, 1'b0});
        end
        $display("test add done");
    endtask

    task automatic t_mul();
        logic signed [79:0] p;
        logic [39:0] a;
        logic [39:0] b;
        a = 40'h40_0000_0000;
        b = 40'hC0_0000_0003;
        p = $signed(a) * $signed(b);
        clr();
        put(10'd100, a);
        put(10'd101, b);
        put(10'd2, {ins(8'hEB, 10'd100), 20'h0});
        run(10'd2);
        check(mq, a);
        put(10'd0, {ins(8'hEB, 10'd100), ins(8'hDA, 10'd101)});
        run(10'd0);
        check(acc, {p[78:40], 1'b1});
        check(mq, 40'h0);
        put(10'd0, {ins(8'hEB, 10'd100), ins(8'hDB, 10'd101)});
        run(10'd0);
        check(acc, p[78:39]);
        check(mq, {1'b0, p[38:0]});
        $display("test mul done");
    endtask

    task automatic t_div();
        logic signed [79:0] n;
        logic signed [79:0] q;
        logic signed [79:0] r;
        logic [39:0] a;
        logic [39:0] d;
        a = 40'h20_0000_0000;
        d = 40'h60_0000_0000;
        n = $signed(a);
        n = n <<< 39;
        q = n / $signed(d);
        r = n - q * $signed(d);
        clr();
        put(10'd100, a);
        put(10'd101, d);
        put(10'd0, {ins(8'hAA, 10'd100), ins(8'hDD, 10'd101)});
        run(10'd0);
        check(mq, q[39:0]);
        check(acc, {r[38:0], 1'b0});
        $display("test div done");
    endtask

    // wrong paths land on halt words or store into 203
    task automatic t_jump();
        logic [39:0] v;
        v = 40'h00_0000_1234;
        clr();
        put(10'd100, v);
        put(10'd0, {ins(8'hAA, 10'd100), ins(8'hCC, 10'd3)});
        put(10'd3, {ins(8'hCB, 10'd5), 20'h0});
        put(10'd5, {20'h0, ins(8'hDC, 10'd200)});
        put(10'd6, {ins(8'hAB, 10'd100), ins(8'hCD, 10'd9)});
        // a left-half CC on a negative acc must fall through to its right half
        put(10'd7, {ins(8'hCC, 10'd9), ins(8'hEB, 10'd100)});
        put(10'd8, {ins(8'hEC, 10'd201), ins(8'hCA, 10'd10)});
        put(10'd9, {ins(8'hDC, 10'd203), ins(8'hDC, 10'd203)});
        put(10'd10, {ins(8'hDC, 10'd202), 20'h0});
        run(10'd0);
        check(i_oeu_mem_model.mem[200], v);
        check(i_oeu_mem_model.mem[201], v);
        check(i_oeu_mem_model.mem[202], -v);
        check(i_oeu_mem_model.mem[203], 40'h0);
        check({pc, right_half}, {10'd10, 1'b1});
        $display("test jump done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        start = 1'b0;
        start_addr = 10'h000;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        t_add();
        t_mul();
        t_div();
        t_jump();
        summarize();
    end

    initial begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
